// ### rtl/qlsl_map.svh
`ifndef QLSL_MAP_SVH
`define QLSL_MAP_SVH

// ****************************************************************
// Timing figures and derived cycle counts
// ****************************************************************
`define QLSL_CLK_PERIOD_NS 10
`define QLSL_DEGLITCH_NS 3500
`define QLSL_DEGLITCH_CYC (`QLSL_DEGLITCH_NS / `QLSL_CLK_PERIOD_NS)
`define QLSL_RETRY_NS 1200000
`define QLSL_RETRY_CYC (`QLSL_RETRY_NS / `QLSL_CLK_PERIOD_NS)
`define QLSL_POR_NS 20000
`define QLSL_POR_CYC (`QLSL_POR_NS / `QLSL_CLK_PERIOD_NS)
`define QLSL_STARTUP_US 55
`define QLSL_STARTUP_CYC ((`QLSL_STARTUP_US * 1000) / `QLSL_CLK_PERIOD_NS)
`define QLSL_RESET_WAIT_US 20
`define QLSL_RESET_WAIT_CYC ((`QLSL_RESET_WAIT_US * 1000) / `QLSL_CLK_PERIOD_NS)
`define QLSL_LATCH_GAP_NS 400
`define QLSL_LATCH_GAP_CYC ((`QLSL_LATCH_GAP_NS + `QLSL_CLK_PERIOD_NS - 1) / `QLSL_CLK_PERIOD_NS + 1)
`define QLSL_LATCH_WIDTH_NS 200
`define QLSL_LATCH_WIDTH_CYC ((`QLSL_LATCH_WIDTH_NS + `QLSL_CLK_PERIOD_NS - 1) / `QLSL_CLK_PERIOD_NS)
`define QLSL_CHANNELS 4
`define QLSL_CHAIN_MAX 8
`define QLSL_SCLK_HALF_CYC 8
`define QLSL_RESET_VAL 4'h0

`endif

// ### rtl/qlsl_pkg.sv
package qlsl_pkg;

	typedef enum logic [2:0] {
		QLSL_H_POWERUP,
		QLSL_H_IDLE,
		QLSL_H_LOW,
		QLSL_H_HIGH,
		QLSL_H_GAP,
		QLSL_H_LATCH
	} qlsl_host_state_t;

	typedef enum logic [1:0] {
		QLSL_OC_OK,
		QLSL_OC_TIMING,
		QLSL_OC_RETRY
	} qlsl_oc_state_t;

endpackage

// ### rtl/qlsl_link_if.sv
`timescale 1ns/1ps

interface qlsl_link_if;
	logic shift_clk;
	logic serial_in;
	logic serial_out;
	logic latch;
	logic outputs_enable_low;
	logic reset;
	logic fault_flag_low_o;
	logic fault_flag_low_oe;

	modport device (
		input shift_clk,
		input serial_in,
		output serial_out,
		input latch,
		input outputs_enable_low,
		input reset,
		output fault_flag_low_o,
		output fault_flag_low_oe
	);

	modport host (
		output shift_clk,
		output serial_in,
		input serial_out,
		output latch,
		output outputs_enable_low,
		output reset,
		input fault_flag_low_o,
		input fault_flag_low_oe
	);
endinterface

// ### rtl/qlsl_device.sv
`timescale 1ns/1ps
`include "qlsl_map.svh"

// Notes on behaviour
// - Rising shift clock shifts serial input in.
// - Holding register is four bits wide.
// - Oldest bit leaves on falling clock edge.
// - Serial output stable at next rising edge.
// - Host clocks eight bits for two devices.
// - Rising latch copies register to outputs.
// - Shifting ignores latch level.
// - Channel on when bit one, enable low.
// - Enable gates only drivers, not logic.
// - Reset high clears logic and fault.
// - Internal power-up reset is generated.
// - Limit over 3.5 us disables channel, fault.
// - Retry 1.2 ms, then fault self-clears.
// - Reset or supply loss clears fault immediately.
// - Overtemperature disables all, flags fault.
// - Supply lockout disables and resets logic.
// - Host waits over 400 ns before latch.
// - Host waits 55 us after power.
// - Host waits 20 us after reset.
module qlsl_device
	import qlsl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	qlsl_link_if.device link,
	input wire logic [3:0] current_limit,
	input wire logic overtemp_shutdown,
	input wire logic supply_lockout,
	output logic [3:0] channel_on,
	output logic [3:0] overcurrent_shutdown,
	output logic device_ready
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [1:0] prev_reg;
	wire [6:0] raw_pins = {link.shift_clk, link.serial_in, link.latch,
		link.outputs_enable_low, link.reset, overtemp_shutdown, supply_lockout};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
			prev_reg <= 2'h0;
		end else begin
			sync1_reg <= raw_pins;
			sync2_reg <= sync1_reg;
			prev_reg <= {sync2_reg[6], sync2_reg[4]};
		end
	end

	wire sclk_s = sync2_reg[6];
	wire sdin_s = sync2_reg[5];
	wire latch_s = sync2_reg[4];
	wire enbl_low_s = sync2_reg[3];
	wire reset_s = sync2_reg[2];
	wire temp_s = sync2_reg[1];
	wire uv_s = sync2_reg[0];
	wire sclk_rise = sclk_s & ~prev_reg[1];
	wire sclk_fall = ~sclk_s & prev_reg[1];
	wire latch_rise = latch_s & ~prev_reg[0];

	// ****************************************************************
	// Internal power-up reset
	// ****************************************************************
	// The counter holds the logic cleared for a while after rstn, as a
	// stand-in for the supply ramp; it restarts whenever lockout is seen.
	logic [15:0] por_cnt_reg;
	wire por_busy = (por_cnt_reg != 16'(`QLSL_POR_CYC));
	wire logic_clear = por_busy | reset_s | uv_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			por_cnt_reg <= 16'h0000;
		end else if (uv_s) begin
			por_cnt_reg <= 16'h0000;
		end else if (por_busy) begin
			por_cnt_reg <= por_cnt_reg + 16'h0001;
		end
	end

	assign device_ready = ~logic_clear;

	// ****************************************************************
	// Serial shift, serial output and latch
	// ****************************************************************
	logic [3:0] shift_reg;
	logic [3:0] latched_reg;
	logic sdout_reg;
	wire [3:0] shift_next = {shift_reg[2:0], sdin_s};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_reg <= `QLSL_RESET_VAL;
			latched_reg <= `QLSL_RESET_VAL;
			sdout_reg <= 1'b0;
		end else if (logic_clear) begin
			shift_reg <= `QLSL_RESET_VAL;
			latched_reg <= `QLSL_RESET_VAL;
			sdout_reg <= 1'b0;
		end else begin
			if (sclk_rise) begin
				shift_reg <= shift_next;
			end
			if (sclk_fall) begin
				sdout_reg <= shift_reg[3];
			end
			if (latch_rise) begin
				latched_reg <= shift_reg;
			end
		end
	end

	assign link.serial_out = sdout_reg;

	// ****************************************************************
	// Per-channel overcurrent deglitch and retry
	// ****************************************************************
	// Counting in the clock domain keeps the intervals exact to one
	// cycle, at the cost of a 21-bit counter per channel.
	wire [3:0] oc_fault;
	for (genvar ch = 0; ch < `QLSL_CHANNELS; ch++) begin : g_oc
		qlsl_oc_state_t oc_state_reg;
		logic [20:0] oc_cnt_reg;
		wire limit_s;
		logic lim1_reg;
		logic lim2_reg;
		assign limit_s = lim2_reg;

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				lim1_reg <= 1'b0;
				lim2_reg <= 1'b0;
			end else begin
				lim1_reg <= current_limit[ch];
				lim2_reg <= lim1_reg;
			end
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				oc_state_reg <= QLSL_OC_OK;
				oc_cnt_reg <= 21'h00_0000;
			end else if (logic_clear) begin
				oc_state_reg <= QLSL_OC_OK;
				oc_cnt_reg <= 21'h00_0000;
			end else begin
				case (oc_state_reg)
					QLSL_OC_OK: begin
						oc_cnt_reg <= 21'h00_0000;
						if (limit_s) begin
							oc_state_reg <= QLSL_OC_TIMING;
						end
					end
					QLSL_OC_TIMING: begin
						if (!limit_s) begin
							oc_state_reg <= QLSL_OC_OK;
						end else if (oc_cnt_reg == 21'(`QLSL_DEGLITCH_CYC - 1)) begin
							oc_state_reg <= QLSL_OC_RETRY;
							oc_cnt_reg <= 21'h00_0000;
						end else begin
							oc_cnt_reg <= oc_cnt_reg + 21'h00_0001;
						end
					end
					QLSL_OC_RETRY: begin
						if (oc_cnt_reg == 21'(`QLSL_RETRY_CYC - 1)) begin
							oc_state_reg <= QLSL_OC_OK;
						end else begin
							oc_cnt_reg <= oc_cnt_reg + 21'h00_0001;
						end
					end
					default: begin
						oc_state_reg <= QLSL_OC_OK;
					end
				endcase
			end
		end

		assign oc_fault[ch] = (oc_state_reg == QLSL_OC_RETRY);
	end

	// ****************************************************************
	// Output drivers and fault pin
	// ****************************************************************
	logic [3:0] chan_reg;
	logic fault_reg;
	wire [3:0] chan_next = (latched_reg & {4{~enbl_low_s}})
		& ~oc_fault & {4{~temp_s}};
	wire fault_next = (|oc_fault) | temp_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chan_reg <= 4'h0;
			fault_reg <= 1'b0;
		end else if (uv_s) begin
			chan_reg <= 4'h0;
			fault_reg <= 1'b0;
		end else begin
			chan_reg <= chan_next;
			fault_reg <= fault_next;
		end
	end

	assign channel_on = chan_reg;
	assign overcurrent_shutdown = oc_fault;
	assign link.fault_flag_low_o = 1'b0;
	assign link.fault_flag_low_oe = fault_reg;

endmodule

// ### rtl/qlsl_host.sv
`timescale 1ns/1ps
`include "qlsl_map.svh"

module qlsl_host
	import qlsl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	qlsl_link_if.host link,
	input wire logic req_valid,
	input wire logic [7:0] req_data,
	input wire logic [3:0] req_bits,
	output logic req_ready,
	input wire logic enable_outputs,
	input wire logic device_reset,
	output logic [7:0] chain_serial_in,
	output logic fault_seen
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] s1_reg;
	logic [1:0] s2_reg;
	wire fault_pin_low = link.fault_flag_low_oe & ~link.fault_flag_low_o;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 2'h0;
			s2_reg <= 2'h0;
		end else begin
			s1_reg <= {link.serial_out, fault_pin_low};
			s2_reg <= s1_reg;
		end
	end

	// ****************************************************************
	// Frame sequencer
	// ****************************************************************
	// Bits leave most significant first, so bit 7 of an eight-bit frame
	// ends in the highest channel of the far device.
	qlsl_host_state_t state_reg;
	logic [15:0] wait_reg;
	logic [7:0] data_reg;
	logic [7:0] cap_reg;
	logic [3:0] left_reg;
	logic sclk_reg;
	logic latch_reg;
	logic reset_reg;
	logic rst_seen_reg;
	wire wait_done = (wait_reg == 16'h0000);
	wire [3:0] bits_req = (req_bits > 4'(`QLSL_CHAIN_MAX)) ? 4'(`QLSL_CHAIN_MAX) : req_bits;

	assign req_ready = (state_reg == QLSL_H_IDLE) & wait_done & ~device_reset;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_reg <= 1'b0;
			rst_seen_reg <= 1'b0;
		end else begin
			reset_reg <= device_reset;
			rst_seen_reg <= device_reset;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= QLSL_H_POWERUP;
			wait_reg <= 16'(`QLSL_STARTUP_CYC);
			data_reg <= 8'h00;
			cap_reg <= 8'h00;
			left_reg <= 4'h0;
			sclk_reg <= 1'b0;
			latch_reg <= 1'b0;
		end else if (rst_seen_reg) begin
			state_reg <= QLSL_H_IDLE;
			// A reset during the power-up wait must not shorten that wait.
			wait_reg <= (wait_reg > 16'(`QLSL_RESET_WAIT_CYC)) ? wait_reg
				: 16'(`QLSL_RESET_WAIT_CYC);
			sclk_reg <= 1'b0;
			latch_reg <= 1'b0;
		end else begin
			case (state_reg)
				QLSL_H_POWERUP: begin
					wait_reg <= wait_reg - 16'h0001;
					if (wait_reg == 16'h0001) begin
						state_reg <= QLSL_H_IDLE;
					end
				end
				QLSL_H_IDLE: begin
					if (!wait_done) begin
						wait_reg <= wait_reg - 16'h0001;
					end else if (req_valid && bits_req != 4'h0) begin
						data_reg <= req_data << (4'(`QLSL_CHAIN_MAX) - bits_req);
						left_reg <= bits_req;
						wait_reg <= 16'(`QLSL_SCLK_HALF_CYC - 1);
						state_reg <= QLSL_H_LOW;
					end
				end
				QLSL_H_LOW: begin
					if (wait_done) begin
						sclk_reg <= 1'b1;
						cap_reg <= {cap_reg[6:0], s2_reg[1]};
						left_reg <= left_reg - 4'h1;
						wait_reg <= 16'(`QLSL_SCLK_HALF_CYC - 1);
						state_reg <= QLSL_H_HIGH;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				QLSL_H_HIGH: begin
					if (wait_done) begin
						sclk_reg <= 1'b0;
						data_reg <= {data_reg[6:0], 1'b0};
						wait_reg <= (left_reg == 4'h0) ? 16'(`QLSL_LATCH_GAP_CYC)
							: 16'(`QLSL_SCLK_HALF_CYC - 1);
						state_reg <= (left_reg == 4'h0) ? QLSL_H_GAP : QLSL_H_LOW;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				QLSL_H_GAP: begin
					if (wait_done) begin
						latch_reg <= 1'b1;
						wait_reg <= 16'(`QLSL_LATCH_WIDTH_CYC);
						state_reg <= QLSL_H_LATCH;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				QLSL_H_LATCH: begin
					if (wait_done) begin
						latch_reg <= 1'b0;
						state_reg <= QLSL_H_IDLE;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				default: begin
					state_reg <= QLSL_H_IDLE;
				end
			endcase
		end
	end

	assign link.shift_clk = sclk_reg;
	assign link.serial_in = data_reg[7];
	assign link.latch = latch_reg;
	assign link.reset = reset_reg;
	assign link.outputs_enable_low = ~enable_outputs;
	assign chain_serial_in = cap_reg;
	assign fault_seen = s2_reg[0];

endmodule

// ### test/qlsl_link_chk.sv
`timescale 1ns/1ps

module qlsl_link_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic shift_clk,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic latch,
	input wire logic outputs_enable_low,
	input wire logic reset,
	input wire logic fault_flag_low_o,
	input wire logic fault_flag_low_oe
);
	// ********************************************************
	// Helper counters
	// ********************************************************
	// The counters saturate, so a long idle spell never wraps back under a bound.
	logic [5:0] low_cnt_reg;
	logic [5:0] high_cnt_reg;
	logic [12:0] rst_cnt_reg;
	logic [12:0] pwr_cnt_reg;
	wire logic low_top = low_cnt_reg == 6'h3f;
	wire logic high_top = high_cnt_reg == 6'h3f;
	wire logic [5:0] low_cnt_next = shift_clk ? 6'h00 : low_cnt_reg + {5'h00, !low_top};
	wire logic [5:0] high_cnt_next = latch ? high_cnt_reg + {5'h00, !high_top} : 6'h00;
	wire logic rst_top = rst_cnt_reg == 13'h1fff;
	wire logic pwr_top = pwr_cnt_reg == 13'h1fff;
	wire logic [12:0] rst_cnt_next = reset ? 13'h0000 : rst_cnt_reg + {12'h000, !rst_top};
	wire logic [12:0] pwr_cnt_next = pwr_cnt_reg + {12'h000, !pwr_top};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt_reg <= 6'h00;
			high_cnt_reg <= 6'h00;
			rst_cnt_reg <= 13'h0000;
			pwr_cnt_reg <= 13'h0000;
		end else begin
			low_cnt_reg <= low_cnt_next;
			high_cnt_reg <= high_cnt_next;
			rst_cnt_reg <= rst_cnt_next;
			pwr_cnt_reg <= pwr_cnt_next;
		end
	end

	// ********************************************************
	// Link assertions
	// ********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_sdo_on_fall: assert property ($changed(serial_out) |-> !shift_clk)
		else $error("serial out moved while shift clock high");
	a_sdo_hold: assert property ($rose(shift_clk) |-> $stable(serial_out) [*3])
		else $error("serial out not steady at rising shift edge");
	a_sdi_hold: assert property ($rose(shift_clk) |=> $stable(serial_in) [*6])
		else $error("serial in moved while shift clock high");
	a_latch_gap: assert property ($rose(latch) |-> low_cnt_reg >= 6'h28)
		else $error("latch rose too soon after shifting");
	a_latch_width: assert property ($fell(latch) |-> high_cnt_reg >= 6'h14)
		else $error("latch pulse too short");
	a_fault_pull: assert property (fault_flag_low_oe |-> !fault_flag_low_o)
		else $error("fault line driven high");
	a_reset_wait: assert property ($rose(shift_clk) |-> rst_cnt_reg >= 13'h07d0)
		else $error("shift clock too soon after device reset");
	a_power_wait: assert property ($rose(shift_clk) |-> pwr_cnt_reg >= 13'h157c)
		else $error("shift clock too soon after power up");
	// The reset pin passes two flip-flops, so the serial output clears three cycles later.
	a_reset_clear: assert property ($rose(reset) |-> ##3 !serial_out)
		else $error("serial out not cleared by device reset");
endmodule

// ### test/test_quad_lowside_serial_latch_ctrl.sv
`timescale 1ns/1ps

module test_quad_lowside_serial_latch_ctrl;
	logic clk, rstn, req_valid, req_ready, enable_outputs, device_reset, fault_seen;
	logic overtemp_shutdown, supply_lockout, device_ready;
	logic [7:0] req_data;
	logic [7:0] chain_serial_in;
	logic [3:0] req_bits, current_limit, channel_on, overcurrent_shutdown;
	int bad_count, total_checks;
	wire logic fault_wire;

	qlsl_link_if link_bus();
	// Open-drain fault line with its pull-up.
	assign fault_wire = link_bus.fault_flag_low_oe ? link_bus.fault_flag_low_o : 1'b1;

	qlsl_device i_qlsl_device(.clk(clk), .rstn(rstn), .link(link_bus),
		.current_limit(current_limit), .overtemp_shutdown(overtemp_shutdown),
		.supply_lockout(supply_lockout), .channel_on(channel_on),
		.overcurrent_shutdown(overcurrent_shutdown), .device_ready(device_ready));
	qlsl_host i_qlsl_host(.clk(clk), .rstn(rstn), .link(link_bus), .req_valid(req_valid),
		.req_data(req_data), .req_bits(req_bits), .req_ready(req_ready),
		.enable_outputs(enable_outputs), .device_reset(device_reset),
		.chain_serial_in(chain_serial_in), .fault_seen(fault_seen));
	qlsl_link_chk i_qlsl_link_chk(.clk(clk), .rstn(rstn), .shift_clk(link_bus.shift_clk),
		.serial_in(link_bus.serial_in), .serial_out(link_bus.serial_out),
		.latch(link_bus.latch), .outputs_enable_low(link_bus.outputs_enable_low),
		.reset(link_bus.reset), .fault_flag_low_o(link_bus.fault_flag_low_o),
		.fault_flag_low_oe(link_bus.fault_flag_low_oe));

	always #5 clk = ~clk;

	// ********************************************************
	// Tasks
	// ********************************************************
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 8000) begin
			settle(1);
			n++;
		end
		if (n == 8000) begin
			bad_count++;
			$display("wrong value at %0t: host never ready", $time);
		end
	endtask

	// The frame is over once the host is ready again, after its latch pulse.
	task send(input logic [7:0] d, input logic [3:0] n);
		wait_ready();
		req_data = d;
		req_bits = n;
		req_valid = 1'b1;
		settle(1);
		req_valid = 1'b0;
		wait_ready();
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#500_000;
		bad_count++;
		$display("wrong value at %0t: run timed out", $time);
		give_verdict();
	end

	// ********************************************************
	// Scenarios
	// ********************************************************
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		req_valid = 1'b0;
		req_data = 8'h00;
		req_bits = 4'h0;
		enable_outputs = 1'b0;
		device_reset = 1'b0;
		current_limit = 4'h0;
		overtemp_shutdown = 1'b0;
		supply_lockout = 1'b0;
		bad_count = 0;
		total_checks = 0;
		settle(3);
		rstn = 1'b1;
		settle(1);
		check({7'h00, device_ready}, 8'h00);
		check({4'h0, channel_on}, 8'h00);
		wait_ready();
		check({7'h00, device_ready}, 8'h01);
		enable_outputs = 1'b1;
		send(8'h0a, 4'h4);
		check({4'h0, channel_on}, 8'h0a);
		check(chain_serial_in, 8'h00);
		send(8'h5c, 4'h8);
		check(chain_serial_in, 8'ha5);
		check({4'h0, channel_on}, 8'h0c);
		enable_outputs = 1'b0;
		settle(8);
		check({4'h0, channel_on}, 8'h00);
		send(8'h03, 4'h4);
		check({4'h0, channel_on}, 8'h00);
		check({4'h0, chain_serial_in[3:0]}, 8'h0c);
		enable_outputs = 1'b1;
		settle(8);
		check({4'h0, channel_on}, 8'h03);
		current_limit = 4'h1;
		settle(300);
		current_limit = 4'h0;
		settle(8);
		check({4'h0, overcurrent_shutdown}, 8'h00);
		current_limit = 4'h1;
		settle(370);
		current_limit = 4'h0;
		check({4'h0, overcurrent_shutdown}, 8'h01);
		settle(8);
		check({4'h0, channel_on}, 8'h02);
		check({6'h00, fault_seen, fault_wire}, 8'h02);
		settle(1000);
		check({4'h0, channel_on}, 8'h02);
		// The other channels stay usable while one waits out its retry.
		send(8'h08, 4'h4);
		check({4'h0, channel_on}, 8'h08);
		check({4'h0, overcurrent_shutdown}, 8'h01);
		device_reset = 1'b1;
		settle(4);
		device_reset = 1'b0;
		settle(8);
		check({4'h0, overcurrent_shutdown}, 8'h00);
		check({4'h0, channel_on}, 8'h00);
		check({6'h00, fault_seen, fault_wire}, 8'h01);
		send(8'h0f, 4'h4);
		check({4'h0, channel_on}, 8'h0f);
		overtemp_shutdown = 1'b1;
		settle(8);
		check({4'h0, channel_on}, 8'h00);
		check({6'h00, fault_seen, fault_wire}, 8'h02);
		overtemp_shutdown = 1'b0;
		settle(8);
		check({4'h0, channel_on}, 8'h0f);
		supply_lockout = 1'b1;
		settle(8);
		check({3'h0, device_ready, channel_on}, 8'h00);
		supply_lockout = 1'b0;
		settle(2100);
		check({7'h00, device_ready}, 8'h01);
		send(8'h09, 4'h4);
		check({4'h0, channel_on}, 8'h09);
		check({4'h0, chain_serial_in[3:0]}, 8'h00);
		// An empty request is ignored and an oversized one is cut to eight bits.
		send(8'h06, 4'h0);
		check({4'h0, channel_on}, 8'h09);
		send(8'h3c, 4'hf);
		check(chain_serial_in, 8'h93);
		check({4'h0, channel_on}, 8'h0c);
		give_verdict();
	end
endmodule
